/* File: sil_device.sv */
`timescale 1ns/1ps
// Overview of operation
// - Entry: high voltage, clock and data low
// - Shift on rising, latch on falling
// - Data pin in and out
// - Serial clock drives shifting and execution
// - Least significant bit first both ways
// - Opcode is low nibble, upper zero
// - Read codes 8 to B, pointer modes
// - Write codes C to F, pointer modes
// - Unlisted special codes go to CPU as zero-extended word
// - Start idle with forced no-op
// - Opcode zero: load sixteen bits, execute
// - Read eight clocks, shift latch out
// - After sixteen clocks fetch next opcode
// - No sixteen-bit table read; writes take sixteen bits
// - One-cycle instruction ends within four clocks
// - Two-cycle: no-op then discarded word
// - Two-word: no-op then operand word
// - Write runs first cycle during data
// - Second write cycle programs sixteen bits
// - Programmer holds clock high for pulse
// - Programming stops when clock falls
// - Programmer holds clock low to discharge
module sil_device #(
    parameter int PTR_W = 22
) (
    sil_link_if.device LINK,              // Serial link
    input wire logic CLOCK_I,             // System clock
    input wire logic SRST_I,              // Sync reset, high
    input wire logic [7:0] RD_BYTE_I,     // Memory byte at pointer
    output logic [PTR_W-1:0] PTR_O,       // Table pointer (sys domain)
    output logic [15:0] INSTR_O,          // Instruction to CPU
    output logic INSTR_STB_O,             // Instruction ready pulse
    output logic [15:0] WR_DATA_O,        // Write data
    output logic PROG_O,                  // Programming pulse active
    output logic ACTIVE_O                 // Programming mode active
);
    if (PTR_W < 2 || PTR_W > 22) begin
        $error("PTR_W out of range");
    end

    sil_pkg::sil_state_e state_r;
    logic [4:0] cnt_r;
    logic [15:0] sh_r;
    logic [7:0] latch_r;
    logic [PTR_W-1:0] ptr_r;
    logic [1:0] mode_r;
    logic dout_r;
    logic doe_r;
    logic wr_pend_r;
    logic prog_lvl;
    logic instr_tgl_r;
    logic [15:0] instr_r;
    logic [15:0] wdat_r;
    logic [2:0] act_sync_r;
    logic drv_neg_r;
    logic ptr_tgl_r;
    logic [PTR_W-1:0] ptr_base;

    function automatic logic [PTR_W-1:0] ptr_step(
        input logic [PTR_W-1:0] p,
        input logic [1:0] m,
        input logic pre
    );
        logic [PTR_W-1:0] r;
        r = p;
        if (pre && m == sil_pkg::PTR_PRE_INC)
            r = p + PTR_W'(1);
        else if (!pre && m == sil_pkg::PTR_POST_INC)
            r = p + PTR_W'(1);
        else if (!pre && m == sil_pkg::PTR_POST_DEC)
            r = p - PTR_W'(1);
        return r;
    endfunction

    // Link logic is held in reset while the high voltage is absent,
    // because the link clock does not run before mode entry
    always_ff @(posedge LINK.sclk or negedge LINK.vpp_high) begin
        if (!LINK.vpp_high) begin
            state_r <= sil_pkg::ST_FETCH;
            cnt_r <= 5'd0;
            sh_r <= 16'h0000;
            ptr_r <= sil_pkg::PTR_RST[PTR_W-1:0];
            latch_r <= 8'h00;
            mode_r <= 2'd0;
            dout_r <= 1'b0;
            doe_r <= 1'b0;
            wr_pend_r <= 1'b0;
            instr_tgl_r <= 1'b0;
            ptr_tgl_r <= 1'b0;
            instr_r <= 16'h0000;
            wdat_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 5'd1;
            case (state_r)
            sil_pkg::ST_FETCH: begin
                // Shift LSB first into top of nibble
                sh_r[3:0] <= {LINK.dat, sh_r[3:1]};
                doe_r <= 1'b0;
                if (cnt_r == 5'd3) begin
                    cnt_r <= 5'd0;
                    mode_r <= sh_r[2:1];
                    ptr_tgl_r <= ~ptr_tgl_r;
                    // A finished write steps its pointer after the pulse
                    wr_pend_r <= 1'b0;
                    ptr_r <= ptr_base;
                    if ({LINK.dat, sh_r[3:1]} == sil_pkg::OPC_NOP) begin
                        state_r <= sil_pkg::ST_WORD;
                    end else if (LINK.dat && !sh_r[3]) begin
                        state_r <= sil_pkg::ST_RDEX;
                        ptr_r <= ptr_step(ptr_base, sh_r[2:1], 1'b1);
                    end else if (LINK.dat && sh_r[3]) begin
                        state_r <= sil_pkg::ST_WRDATA;
                        ptr_r <= ptr_step(ptr_base, sh_r[2:1], 1'b1);
                    end else begin
                        state_r <= sil_pkg::ST_FETCH;
                        instr_r <= {12'h000, LINK.dat, sh_r[3:1]};
                        instr_tgl_r <= ~instr_tgl_r;
                    end
                end
            end
            sil_pkg::ST_WORD: begin
                sh_r <= {LINK.dat, sh_r[15:1]};
                if (cnt_r == 5'd15) begin
                    cnt_r <= 5'd0;
                    // Word executes while next nibble shifts in
                    instr_r <= {LINK.dat, sh_r[15:1]};
                    instr_tgl_r <= ~instr_tgl_r;
                    state_r <= sil_pkg::ST_FETCH;
                end
            end
            sil_pkg::ST_RDEX: begin
                if (cnt_r == 5'd7) begin
                    cnt_r <= 5'd0;
                    latch_r <= RD_BYTE_I;
                    ptr_r <= ptr_step(ptr_r, mode_r, 1'b0);
                    ptr_tgl_r <= ~ptr_tgl_r;
                    state_r <= sil_pkg::ST_RDOUT;
                end
            end
            sil_pkg::ST_RDOUT: begin
                // Each read-out clock puts the next bit out on its rise
                dout_r <= latch_r[0];
                latch_r <= {1'b0, latch_r[7:1]};
                doe_r <= 1'b1;
                if (cnt_r == 5'd7) begin
                    cnt_r <= 5'd0;
                    state_r <= sil_pkg::ST_FETCH;
                end
            end
            sil_pkg::ST_WRDATA: begin
                sh_r <= {LINK.dat, sh_r[15:1]};
                if (cnt_r == 5'd15) begin
                    cnt_r <= 5'd0;
                    wdat_r <= {LINK.dat, sh_r[15:1]};
                    wr_pend_r <= 1'b1;
                    state_r <= sil_pkg::ST_FETCH;
                end
            end
            default: state_r <= sil_pkg::ST_FETCH;
            endcase
        end
    end

    // Programming while clock high in the write cycle; falls with clock
    assign prog_lvl = LINK.sclk && wr_pend_r && LINK.vpp_high;

    // Pin is let go on the fall that ends the last read-out bit, before
    // the programmer drives the next opcode
    always_ff @(negedge LINK.sclk or negedge LINK.vpp_high) begin
        if (!LINK.vpp_high) begin
            drv_neg_r <= 1'b0;
        end else begin
            drv_neg_r <= state_r == sil_pkg::ST_RDOUT;
        end
    end

    assign ptr_base = wr_pend_r ? ptr_step(ptr_r, mode_r, 1'b0) : ptr_r;
    assign LINK.dat_dev = dout_r;
    assign LINK.dat_dev_oe = doe_r && drv_neg_r;

    // System domain: three-stage sync on levels, toggle for instruction
    logic [2:0] tgl_sync_r;
    logic [2:0] prog_sync_r;
    logic [2:0] ptr_sync_r;
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            act_sync_r <= 3'b000;
            tgl_sync_r <= 3'b000;
            prog_sync_r <= 3'b000;
            ptr_sync_r <= 3'b000;
            ACTIVE_O <= 1'b0;
            PROG_O <= 1'b0;
            INSTR_STB_O <= 1'b0;
            INSTR_O <= 16'h0000;
            WR_DATA_O <= 16'h0000;
            PTR_O <= '0;
        end else begin
            act_sync_r <= {act_sync_r[1:0], LINK.vpp_high};
            tgl_sync_r <= {tgl_sync_r[1:0], instr_tgl_r};
            prog_sync_r <= {prog_sync_r[1:0], prog_lvl};
            ptr_sync_r <= {ptr_sync_r[1:0], ptr_tgl_r};
            if (act_sync_r[2] == act_sync_r[1])
                ACTIVE_O <= act_sync_r[1];
            if (prog_sync_r[2] == prog_sync_r[1])
                PROG_O <= prog_sync_r[1];
            INSTR_STB_O <= tgl_sync_r[2] != tgl_sync_r[1];
            if (tgl_sync_r[2] != tgl_sync_r[1])
                INSTR_O <= instr_r;
            if (prog_sync_r[1] && prog_sync_r[2])
                WR_DATA_O <= wdat_r;
            // Pointer stands for many link clocks after each toggle
            if (ptr_sync_r[2] != ptr_sync_r[1])
                PTR_O <= ptr_r;
        end
    end
endmodule

/* File: sil_pkg.sv */
package sil_pkg;
    localparam int OPC_W = 4;
    localparam int INSTR_W = 16;
    localparam int LATCH_W = 8;
    localparam int EXEC_CLKS = 4;
    localparam int READ_CLKS = 8;
    localparam logic [3:0] OPC_NOP = 4'h0;
    localparam logic [3:0] OPC_RD_BASE = 4'h8;
    localparam logic [3:0] OPC_WR_BASE = 4'hC;
    localparam logic [1:0] PTR_KEEP = 2'h0;
    localparam logic [1:0] PTR_POST_INC = 2'h1;
    localparam logic [1:0] PTR_POST_DEC = 2'h2;
    localparam logic [1:0] PTR_PRE_INC = 2'h3;
    localparam logic [21:0] PTR_RST = 22'h00_0000;
    localparam int DIV_HALF = 8;

    typedef enum logic [4:0] {
        ST_FETCH = 5'b0_0001,
        ST_WORD = 5'b0_0010,
        ST_RDEX = 5'b0_0100,
        ST_RDOUT = 5'b0_1000,
        ST_WRDATA = 5'b1_0000
    } sil_state_e;
endpackage

/* File: sil_link_if.sv */
`timescale 1ns/1ps
interface sil_link_if;
    logic sclk;
    logic dat_prg;
    logic dat_prg_oe;
    logic dat_dev;
    logic dat_dev_oe;
    logic vpp_high;
    wire dat = dat_dev_oe ? dat_dev : (dat_prg_oe ? dat_prg : 1'b0);

    modport device (
        input sclk,
        input vpp_high,
        input dat,
        output dat_dev,
        output dat_dev_oe
    );
    modport programmer (
        output sclk,
        output vpp_high,
        output dat_prg,
        output dat_prg_oe,
        input dat
    );
endinterface

/* File: sil_programmer.sv */
`timescale 1ns/1ps
module sil_programmer (
    sil_link_if.programmer LINK,          // Serial link
    input wire logic CLOCK_I,             // System clock
    input wire logic SRST_I,              // Sync reset, high
    input wire logic ENTER_I,             // Hold high for mode
    input wire logic GO_I,                // Start a transfer pulse
    input wire logic [4:0] NBITS_I,       // Bits to clock (1..16)
    input wire logic [15:0] WORD_I,       // Bits to send, LSB first
    input wire logic LISTEN_I,            // Release data, capture
    input wire logic HOLD_HIGH_I,         // Hold clock high after last
    output logic [15:0] RX_O,             // Captured bits
    output logic BUSY_O,                  // Transfer in progress
    output logic SCLK_HIGH_O              // Clock held high
);
    logic [3:0] div_r;
    logic [4:0] left_r;
    logic [15:0] tx_r;
    logic sclk_r;
    logic [2:0] dsync_r;
    logic listen_r;
    logic hold_r;

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            div_r <= 4'h0;
            left_r <= 5'd0;
            tx_r <= 16'h0000;
            sclk_r <= 1'b0;
            listen_r <= 1'b0;
            hold_r <= 1'b0;
            RX_O <= 16'h0000;
            BUSY_O <= 1'b0;
            SCLK_HIGH_O <= 1'b0;
            dsync_r <= 3'b000;
        end else begin
            dsync_r <= {dsync_r[1:0], LINK.dat};
            if (GO_I && !BUSY_O && NBITS_I != 5'd0) begin
                left_r <= NBITS_I;
                tx_r <= WORD_I;
                listen_r <= LISTEN_I;
                hold_r <= HOLD_HIGH_I;
                BUSY_O <= 1'b1;
                sclk_r <= 1'b0;
                div_r <= 4'h0;
            end else if (BUSY_O) begin
                div_r <= div_r + 4'h1;
                if (div_r == 4'(sil_pkg::DIV_HALF - 1)) begin
                    div_r <= 4'h0;
                    if (!sclk_r) begin
                        sclk_r <= 1'b1; // Rising edge shifts
                    end else if (left_r == 5'd1 && hold_r) begin
                        BUSY_O <= 1'b0;
                        SCLK_HIGH_O <= 1'b1;
                        left_r <= 5'd0;
                    end else begin
                        sclk_r <= 1'b0;
                        tx_r <= {1'b0, tx_r[15:1]};
                        if (dsync_r[2] == dsync_r[1])
                            RX_O <= {dsync_r[1], RX_O[15:1]};
                        left_r <= left_r - 5'd1;
                        if (left_r == 5'd1)
                            BUSY_O <= 1'b0;
                    end
                end
            end else if (SCLK_HIGH_O && !HOLD_HIGH_I) begin
                sclk_r <= 1'b0;
                SCLK_HIGH_O <= 1'b0;
            end
        end
    end

    assign LINK.sclk = sclk_r;
    assign LINK.vpp_high = ENTER_I;
    assign LINK.dat_prg = tx_r[0];
    assign LINK.dat_prg_oe = ENTER_I && !listen_r;
endmodule

/* File: sil_link_props.sv */
`timescale 1ns/1ps
module sil_link_props (
    input wire logic CLOCK_I, // System clock
    input wire logic SRST_I, // Sync reset
    input wire logic sclk, // Link clock
    input wire logic dat_prg, // Programmer data
    input wire logic dat_prg_oe, // Programmer enable
    input wire logic dat_dev, // Device data
    input wire logic dat_dev_oe, // Device enable
    input wire logic vpp_high, // Mode entry
    input wire logic dat // Resolved data
);
    localparam int SPAN = 2 * sil_pkg::DIV_HALF * sil_pkg::READ_CLKS;
    int oe_cnt_r = 0;
    // Length of one device drive window in system clocks
    always_ff @(posedge CLOCK_I) begin
        if (!dat_dev_oe) begin
            oe_cnt_r <= 0;
        end else begin
            oe_cnt_r <= oe_cnt_r + 1;
        end
    end
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    AST_ENTRY_QUIET: assert property ($rose(vpp_high) |-> !sclk && !dat)
        else $error("link not quiet at mode entry");
    AST_NO_FIGHT: assert property (dat_dev_oe |-> !dat_prg_oe)
        else $error("both ends drive data");
    AST_OE_IN_MODE: assert property (dat_dev_oe |-> vpp_high)
        else $error("device drives outside mode");
    AST_OUT_CHANGE: assert property (
        dat_dev_oe && $past(dat_dev_oe) && $changed(dat_dev) |-> sclk)
        else $error("device data changed while clock low");
    AST_OE_SPAN: assert property ($fell(dat_dev_oe) |->
        oe_cnt_r >= SPAN - 16 && oe_cnt_r <= SPAN + 16)
        else $error("read-out window not eight clocks");
    AST_ENTRY_NO_DRIVE: assert property (
        $rose(vpp_high) |-> !dat_dev_oe [*8])
        else $error("device drives at mode entry");
    AST_SCLK_HIGH_MIN: assert property ($rose(sclk) |-> sclk [*8])
        else $error("clock high phase too short");
    AST_SCLK_LOW_MIN: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("clock low phase too short");
    cover property ($rose(vpp_high));
    cover property ($rose(dat_dev_oe));
    cover property (sclk [*8] ##1 sclk);
endmodule

/* File: serial_instruction_loader_bench.sv */
`timescale 1ns/1ps
module serial_instruction_loader_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] rd_byte = 8'h00;
    logic enter = 1'b1;
    logic go = 1'b0;
    logic lsn = 1'b0;
    logic hold = 1'b0;
    logic [4:0] nbits = 5'h01;
    logic [15:0] word = 16'h0000;
    logic [21:0] exp_ptr = 22'h00_0000;
    logic [21:0] ptr;
    logic [15:0] instr, wr_data, rx;
    logic stb, prog, active, busy, sclk_high;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int stbs = 0;
    sil_link_if link ();
    always #50 clk = ~clk;
    sil_device u_sil_device (.LINK(link), .CLOCK_I(clk), .SRST_I(srst),
        .RD_BYTE_I(rd_byte), .PTR_O(ptr), .INSTR_O(instr),
        .INSTR_STB_O(stb), .WR_DATA_O(wr_data), .PROG_O(prog),
        .ACTIVE_O(active));
    sil_programmer u_sil_programmer (.LINK(link), .CLOCK_I(clk),
        .SRST_I(srst), .ENTER_I(enter), .GO_I(go), .NBITS_I(nbits),
        .WORD_I(word), .LISTEN_I(lsn), .HOLD_HIGH_I(hold), .RX_O(rx),
        .BUSY_O(busy), .SCLK_HIGH_O(sclk_high));
    sil_link_props u_sil_link_props (.CLOCK_I(clk), .SRST_I(srst),
        .sclk(link.sclk), .dat_prg(link.dat_prg),
        .dat_prg_oe(link.dat_prg_oe), .dat_dev(link.dat_dev),
        .dat_dev_oe(link.dat_dev_oe), .vpp_high(link.vpp_high),
        .dat(link.dat));
    task automatic end_sim();
        $display("Checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Run needs about 6800 cycles
    // Strobe counted away from the edge that launches it
    always @(negedge clk) begin
        if (stb === 1'b1) begin
            stbs++;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [21:0] exp,
            input logic [21:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_idle();
        int k = 0;
        while (busy !== 1'b0 && k < 400) begin
            tick(1);
            k++;
        end
    endtask
    task automatic send(input int n, input logic [15:0] w, input logic l);
        nbits = 5'(n);
        word = w;
        lsn = l;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        wait_idle();
    endtask
    task automatic move_ptr(input logic [1:0] m);
        if (m == sil_pkg::PTR_POST_DEC) begin
            exp_ptr = exp_ptr - 22'h00_0001;
        end else if (m != sil_pkg::PTR_KEEP) begin
            exp_ptr = exp_ptr + 22'h00_0001;
        end
    endtask
    task automatic op_read(input logic [3:0] code, input logic [7:0] b);
        rd_byte = b;
        send(4, {12'h000, code}, 1'b0);
        send(8, 16'h0000, 1'b0);
        send(8, 16'h0000, 1'b1);
        check("read byte", 22'(b), 22'(rx[15:8]));
        move_ptr(code[1:0]);
        tick(8);
        check("pointer", exp_ptr, ptr);
    endtask
    task automatic t_word(input logic [15:0] w);
        int s0;
        send(4, 16'h0000, 1'b0);
        s0 = stbs;
        send(16, w, 1'b0);
        send(4, 16'h0000, 1'b0);
        check("instruction", 22'(w), 22'(instr));
        check("strobes", 22'h00_0001, 22'(stbs - s0));
        send(16, 16'h0000, 1'b0);
    endtask
    task automatic t_codes();
        for (int c = 8; c < 12; c++) begin
            op_read(4'(c), 8'hA5 ^ 8'(c));
        end
        for (int c = 1; c < 8; c++) begin
            send(4, 16'(c), 1'b0);
        end
        op_read(4'h8, 8'h3C);
    endtask
    task automatic t_writes();
        logic [15:0] d;
        for (int c = 12; c < 16; c++) begin
            d = 16'hC0DE ^ 16'(c);
            send(4, 16'(c), 1'b0);
            send(16, d, 1'b0);
            move_ptr(2'(c));
            op_read(4'h8, 8'h69);
            check("write data", 22'(d), 22'(wr_data));
        end
    endtask
    task automatic t_pulse();
        int k = 0;
        send(4, 16'h000C, 1'b0);
        send(16, 16'hBEEF, 1'b0);
        hold = 1'b1;
        send(1, 16'h0000, 1'b0);
        while (sclk_high !== 1'b1 && k < 100) begin
            tick(1);
            k++;
        end
        tick(16);
        check("pulse on", 22'h00_0001, 22'(prog));
        hold = 1'b0;
        tick(2);
        wait_idle();
        tick(4);
        check("pulse off", 22'h00_0000, 22'(prog));
        check("programmed", 22'h00_BEEF, 22'(wr_data));
        send(3, 16'h0000, 1'b0);
        send(16, 16'h0000, 1'b0);
    endtask
    initial begin
        // A clean fall of the mode level resets the link logic
        tick(1);
        enter = 1'b0;
        tick(9);
        srst = 1'b0;
        enter = 1'b1;
        tick(40);
        check("active", 22'h00_0001, 22'(active));
        op_read(4'h8, 8'h96);
        t_word(16'hA53C);
        t_codes();
        t_writes();
        t_pulse();
        op_read(4'hB, 8'h5A);
        end_sim();
    end
endmodule
